// file: design/adc_conv_params.svh
// Constants for the converter control block: offsets, fields, timing and reset values
`ifndef ADC_CONV_PARAMS_SVH
`define ADC_CONV_PARAMS_SVH

`define ADC_ADDR_W          8
`define ADC_OFS_SCR         8'h00
`define ADC_OFS_CFG         8'h04
`define ADC_OFS_RES_HIGH    8'h08
`define ADC_OFS_RES_LOW     8'h0C
`define ADC_OFS_IRQ_STS     8'h10
`define ADC_OFS_IRQ_MSK     8'h14

`define SCR_DONE_BIT        7
`define SCR_IRQ_EN_BIT      6
`define SCR_CONT_BIT        5
`define SCR_CHAN_MSB        4
`define SCR_CHAN_OFF        5'h1F

`define CFG_LONG_BIT        0
`define CFG_MODE8_BIT       1
`define CFG_ASYNC_BIT       2
`define CFG_HWTRIG_BIT      3
`define CFG_W               4

`define IRQ_DONE_BIT        0
`define IRQ_ABORT_BIT       1
`define IRQ_W               2

// Sample windows counted in converter half cycles: 3.5 and 23.5 cycles
`define SAMPLE_SHORT_HALF   6'h07
`define SAMPLE_LONG_HALF    6'h2F
`define RES_W               10
`define RES_MSB_CODE        10'h200
`define ROUND_ADD           11'h002
`define RES8_MAX            8'hFF

`endif

// file: design/adc_conv_pkg.sv
// Types shared by the converter control block
package adc_conv_pkg;
   typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_APPROX} sar_state_t;
endpackage : adc_conv_pkg

// file: design/adc_clk_div.sv
// Converter clock divider: half-period tick, stopped while the converter is idle
module adc_clk_div #(
   parameter int DIV_HALF = 4
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic run,
   output logic      half_tick
);
   localparam int CW = $clog2(DIV_HALF + 1);
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic          tick_ff;
   logic          nxt_tick;

   always_comb
   begin
      nxt_cnt  = cnt_ff;
      nxt_tick = 1'b0;
      // Held at zero when idle so the clock is gated off in low power
      if (!run)
      begin
         nxt_cnt = '0;
      end
      else if (cnt_ff == CW'(DIV_HALF - 1))
      begin
         nxt_cnt  = '0;
         nxt_tick = 1'b1;
      end
      else
      begin
         nxt_cnt = cnt_ff + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_ff  <= '0;
         tick_ff <= 1'b0;
      end
      else
      begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign half_tick = tick_ff;
endmodule : adc_clk_div

// file: design/adc_sar_engine.sv
// Successive-approximation sequencer: sample window then one bit per converter cycle
`include "adc_conv_params.svh"
module adc_sar_engine
   import adc_conv_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  half_tick,
   input  wire logic                  start,
   input  wire logic                  abort,
   input  wire logic                  long_sample,
   input  wire logic                  comp_high,
   output logic                       busy,
   output logic                       sample_on,
   output logic [`RES_W-1:0]          dac_code,
   output logic                       done,
   output logic [`RES_W-1:0]          result
);
   import adc_conv_pkg::*;

   sar_state_t        state_ff, nxt_state;
   logic [5:0]        cnt_ff, nxt_cnt;
   logic [3:0]        bit_ff, nxt_bit;
   logic              phase_ff, nxt_phase;
   logic [`RES_W-1:0] code_ff, nxt_code;
   logic              done_ff, nxt_done;
   logic              busy_ff, nxt_busy;
   logic              sample_ff, nxt_sample;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_bit   = bit_ff;
      nxt_phase = phase_ff;
      nxt_code  = code_ff;
      nxt_done  = 1'b0;
      case (state_ff)
         SAR_IDLE:
         begin
         end
         SAR_SAMPLE:
         begin
            if (half_tick)
            begin
               if (cnt_ff == 6'h01)
               begin
                  nxt_state = SAR_APPROX;
                  nxt_bit   = 4'(`RES_W - 1);
                  nxt_phase = 1'b0;
                  nxt_code  = `RES_MSB_CODE;
               end
               else
               begin
                  nxt_cnt = cnt_ff - 6'h01;
               end
            end
         end
         SAR_APPROX:
         begin
            if (half_tick)
            begin
               nxt_phase = !phase_ff;
               // Comparator is judged on the second half so the array has settled
               if (phase_ff)
               begin
                  nxt_code[bit_ff] = comp_high;
                  if (bit_ff == 4'h0)
                  begin
                     nxt_state = SAR_IDLE;
                     nxt_done  = 1'b1;
                  end
                  else
                  begin
                     nxt_code[bit_ff - 4'h1] = 1'b1;
                     nxt_bit = bit_ff - 4'h1;
                  end
               end
            end
         end
         default:
         begin
            nxt_state = SAR_IDLE;
         end
      endcase
      if (abort)
      begin
         nxt_state = SAR_IDLE;
         nxt_done  = 1'b0;
      end
      if (start)
      begin
         nxt_state = SAR_SAMPLE;
         nxt_cnt   = long_sample ? `SAMPLE_LONG_HALF : `SAMPLE_SHORT_HALF;
         nxt_code  = '0;
      end
      // Registered so the status outputs come straight from flip-flops
      nxt_busy   = (nxt_state != SAR_IDLE);
      nxt_sample = (nxt_state == SAR_SAMPLE);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= SAR_IDLE;
         cnt_ff   <= '0;
         bit_ff   <= '0;
         phase_ff <= 1'b0;
         code_ff  <= '0;
         done_ff  <= 1'b0;
         busy_ff   <= 1'b0;
         sample_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         bit_ff   <= nxt_bit;
         phase_ff <= nxt_phase;
         code_ff  <= nxt_code;
         done_ff  <= nxt_done;
         busy_ff   <= nxt_busy;
         sample_ff <= nxt_sample;
      end
   end

   assign busy      = busy_ff;
   assign sample_on = sample_ff;
   assign dac_code  = code_ff;
   assign done      = done_ff;
   assign result    = code_ff;
endmodule : adc_sar_engine

// file: design/adc_conversion_power_ctrl.sv
// Converter control top: APB registers, start/abort, stop handling, results, interrupts
module adc_conversion_power_ctrl
   import adc_conv_pkg::*;
#(
   parameter int DIV_HALF = 4
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   stop_mode,
   input  wire logic                   external_trigger,
   input  wire logic                   comp_high,
   output logic                        converter_active,
   output logic                        sample_on,
   output logic [9:0]                  dac_code,
   output logic                        conv_irq_req,
   output logic                        irq
);
   import adc_conv_pkg::*;
   `include "adc_conv_params.svh"

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic              trig_s1_ff, trig_s2_ff, trig_s3_ff;
   logic              comp_s1_ff, comp_s2_ff;
   logic              irq_en_ff, nxt_irq_en;
   logic              cont_ff, nxt_cont;
   logic [4:0]        chan_ff, nxt_chan;
   logic [`CFG_W-1:0] cfg_ff, nxt_cfg;
   logic              done_ff, nxt_done;
   logic [`RES_W-1:0] result_ff, nxt_result;
   logic              hi_read_ff, nxt_hi_read;
   logic              active_ff, nxt_active;
   logic [`IRQ_W-1:0] sts_ff, nxt_sts;
   logic [`IRQ_W-1:0] msk_ff, nxt_msk;
   logic [31:0]       prdata_ff, nxt_prdata;
   logic              pready_ff, nxt_pready;
   logic              pslverr_ff, nxt_pslverr;
   logic              conv_irq_ff, nxt_conv_irq;
   logic              irq_ff, nxt_irq;
   logic              half_tick, eng_busy, eng_done, eng_start, eng_abort;
   logic [`RES_W-1:0] eng_result;
   logic              wr, rd, scr_wr, stop_abort, hw_mode, blocked, chan_off, trig_edge;
   logic [10:0]       rsum;

   adc_clk_div #(.DIV_HALF(DIV_HALF)) u_div (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (eng_busy),
      .half_tick (half_tick)
   );

   adc_sar_engine u_sar (
      .pclk        (pclk),
      .presetn     (presetn),
      .half_tick   (half_tick),
      .start       (eng_start),
      .abort       (eng_abort),
      .long_sample (cfg_ff[`CFG_LONG_BIT]),
      .comp_high   (comp_s2_ff),
      .busy        (eng_busy),
      .sample_on   (sample_on),
      .dac_code    (dac_code),
      .done        (eng_done),
      .result      (eng_result)
   );

   // Pins from outside the clock domain
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trig_s1_ff <= 1'b0;
         trig_s2_ff <= 1'b0;
         trig_s3_ff <= 1'b0;
         comp_s1_ff <= 1'b0;
         comp_s2_ff <= 1'b0;
      end
      else
      begin
         trig_s1_ff <= external_trigger;
         trig_s2_ff <= trig_s1_ff;
         trig_s3_ff <= trig_s2_ff;
         comp_s1_ff <= comp_high;
         comp_s2_ff <= comp_s1_ff;
      end
   end

   always_comb
   begin
      wr         = psel && penable && pready_ff && pwrite;
      rd         = psel && penable && pready_ff && !pwrite;
      scr_wr     = wr && hit(paddr, `ADC_OFS_SCR);
      chan_off   = (pwdata[`SCR_CHAN_MSB:0] == `SCR_CHAN_OFF);
      hw_mode    = cfg_ff[`CFG_HWTRIG_BIT];
      trig_edge  = trig_s2_ff && !trig_s3_ff;
      // Wait mode is deliberately not an input: nothing here gates on it
      stop_abort = stop_mode && !cfg_ff[`CFG_ASYNC_BIT];
      blocked    = hi_read_ff && !cfg_ff[`CFG_MODE8_BIT];
      eng_abort  = scr_wr || stop_abort;
      eng_start  = 1'b0;
      if (!stop_abort)
      begin
         if (scr_wr && !chan_off && !hw_mode)
         begin
            eng_start = 1'b1;
         end
         else if (!scr_wr && hw_mode && active_ff && trig_edge && !eng_busy)
         begin
            eng_start = 1'b1;
         end
         else if (!scr_wr && eng_done && active_ff && (cont_ff || blocked))
         begin
            eng_start = 1'b1;
         end
      end
   end

   // Conversion control, result and flag
   always_comb
   begin
      nxt_irq_en  = irq_en_ff;
      nxt_cont    = cont_ff;
      nxt_chan    = chan_ff;
      nxt_cfg     = cfg_ff;
      nxt_active  = active_ff;
      nxt_result  = result_ff;
      nxt_done    = done_ff;
      nxt_hi_read = hi_read_ff;
      rsum        = {1'b0, eng_result} + `ROUND_ADD;
      if (wr && hit(paddr, `ADC_OFS_CFG))
      begin
         nxt_cfg = pwdata[`CFG_W-1:0];
      end
      if (rd && hit(paddr, `ADC_OFS_RES_HIGH) && !cfg_ff[`CFG_MODE8_BIT])
      begin
         nxt_hi_read = 1'b1;
      end
      if (rd && hit(paddr, `ADC_OFS_RES_LOW))
      begin
         nxt_hi_read = 1'b0;
         nxt_done    = 1'b0;
      end
      if (eng_done && !cont_ff && !blocked && !hw_mode)
      begin
         nxt_active = 1'b0;
      end
      if (scr_wr)
      begin
         nxt_irq_en = pwdata[`SCR_IRQ_EN_BIT];
         nxt_cont   = pwdata[`SCR_CONT_BIT];
         nxt_chan   = pwdata[`SCR_CHAN_MSB:0];
         nxt_active = !chan_off;
         nxt_done   = 1'b0;
      end
      if (stop_abort)
      begin
         nxt_active = 1'b0;
      end
      // A blocked transfer drops the new result; aborts never touch the result
      if (eng_done && !blocked)
      begin
         if (cfg_ff[`CFG_MODE8_BIT])
         begin
            nxt_result = {2'b00, rsum[10] ? `RES8_MAX : rsum[9:2]};
         end
         else
         begin
            nxt_result = eng_result;
         end
         nxt_done = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_en_ff  <= 1'b0;
         cont_ff    <= 1'b0;
         chan_ff    <= `SCR_CHAN_OFF;
         cfg_ff     <= '0;
         active_ff  <= 1'b0;
         result_ff  <= '0;
         done_ff    <= 1'b0;
         hi_read_ff <= 1'b0;
      end
      else
      begin
         irq_en_ff  <= nxt_irq_en;
         cont_ff    <= nxt_cont;
         chan_ff    <= nxt_chan;
         cfg_ff     <= nxt_cfg;
         active_ff  <= nxt_active;
         result_ff  <= nxt_result;
         done_ff    <= nxt_done;
         hi_read_ff <= nxt_hi_read;
      end
   end

   // Interrupts and APB answer; one wait state so every output is registered
   always_comb
   begin
      nxt_sts = sts_ff;
      nxt_msk = msk_ff;
      if (wr && hit(paddr, `ADC_OFS_IRQ_STS))
      begin
         nxt_sts = sts_ff & ~pwdata[`IRQ_W-1:0];
      end
      if (wr && hit(paddr, `ADC_OFS_IRQ_MSK))
      begin
         nxt_msk = pwdata[`IRQ_W-1:0];
      end
      if (eng_done && !blocked)
      begin
         nxt_sts[`IRQ_DONE_BIT] = 1'b1;
      end
      if (eng_abort && eng_busy)
      begin
         nxt_sts[`IRQ_ABORT_BIT] = 1'b1;
      end
      nxt_conv_irq = nxt_done && nxt_irq_en;
      nxt_irq      = |(nxt_sts & nxt_msk);
      nxt_pready   = psel && penable && !pready_ff;
      nxt_pslverr  = 1'b0;
      nxt_prdata   = '0;
      if (psel && penable && !pready_ff)
      begin
         case (paddr)
            `ADC_OFS_SCR:
            begin
               nxt_prdata[`SCR_DONE_BIT]       = done_ff;
               nxt_prdata[`SCR_IRQ_EN_BIT]     = irq_en_ff;
               nxt_prdata[`SCR_CONT_BIT]       = cont_ff;
               nxt_prdata[`SCR_CHAN_MSB:0]     = chan_ff;
            end
            `ADC_OFS_CFG:      nxt_prdata[`CFG_W-1:0] = cfg_ff;
            `ADC_OFS_RES_HIGH: nxt_prdata[1:0]        = result_ff[9:8];
            `ADC_OFS_RES_LOW:  nxt_prdata[7:0]        = result_ff[7:0];
            `ADC_OFS_IRQ_STS:  nxt_prdata[`IRQ_W-1:0] = sts_ff;
            `ADC_OFS_IRQ_MSK:  nxt_prdata[`IRQ_W-1:0] = msk_ff;
            default:           nxt_pslverr            = 1'b1;
         endcase
         if (pwrite)
         begin
            nxt_prdata = '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sts_ff      <= '0;
         msk_ff      <= '0;
         conv_irq_ff <= 1'b0;
         irq_ff      <= 1'b0;
         pready_ff   <= 1'b0;
         pslverr_ff  <= 1'b0;
         prdata_ff   <= 32'h0000_0000;
      end
      else
      begin
         sts_ff      <= nxt_sts;
         msk_ff      <= nxt_msk;
         conv_irq_ff <= nxt_conv_irq;
         irq_ff      <= nxt_irq;
         pready_ff   <= nxt_pready;
         pslverr_ff  <= nxt_pslverr;
         prdata_ff   <= nxt_prdata;
      end
   end

   assign prdata           = prdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = pslverr_ff;
   assign conv_irq_req     = conv_irq_ff;
   assign irq              = irq_ff;
   assign converter_active = eng_busy;
endmodule : adc_conversion_power_ctrl

// file: dv/adc_ctrl_properties.sv
// Port-level checks of the converter control top
`include "adc_conv_params.svh"
module adc_ctrl_props #(
   parameter int DIV_HALF = 4
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        stop_mode,
   input wire logic        converter_active,
   input wire logic        sample_on,
   input wire logic        conv_irq_req,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SH = 7 * DIV_HALF;
   localparam int LH = 47 * DIV_HALF;
   logic       wr;
   logic [3:0] cfg_ff;
   logic [3:0] nxt_cfg;
   logic [1:0] mask_ff;
   logic [1:0] nxt_mask;
   logic [8:0] scnt_ff;
   logic [8:0] nxt_scnt;
   assign wr = psel && penable && pready && pwrite;
   // Shadow copies so the checks know the mode the design runs in
   always_comb
   begin
      nxt_cfg  = (wr && paddr == `ADC_OFS_CFG) ? pwdata[3:0] : cfg_ff;
      nxt_mask = (wr && paddr == `ADC_OFS_IRQ_MSK) ? pwdata[1:0] : mask_ff;
      nxt_scnt = sample_on ? scnt_ff + 9'h001 : 9'h000;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_ff  <= 4'h0;
         mask_ff <= 2'h0;
         scnt_ff <= 9'h000;
      end
      else
      begin
         cfg_ff  <= nxt_cfg;
         mask_ff <= nxt_mask;
         scnt_ff <= nxt_scnt;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready not one cycle after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("prdata not zero outside answer");
   sample_len_a: assert property ($fell(sample_on) && converter_active |->
      (scnt_ff >= SH - DIV_HALF && scnt_ff <= SH + DIV_HALF) ||
      (scnt_ff >= LH - DIV_HALF && scnt_ff <= LH + DIV_HALF))
      else $error("sample window length wrong");
   sample_first_a: assert property ($rose(converter_active) |-> sample_on)
      else $error("conversion began without sampling");
   start_a: assert property (wr && paddr == `ADC_OFS_SCR && !stop_mode &&
      pwdata[4:0] != `SCR_CHAN_OFF && !cfg_ff[`CFG_HWTRIG_BIT] |-> ##[1:4] converter_active)
      else $error("write did not start conversion");
   off_write_a: assert property (wr && paddr == `ADC_OFS_SCR &&
      pwdata[4:0] == `SCR_CHAN_OFF |-> ##3 (!converter_active)[*6])
      else $error("converter active after channel off");
   stop_abort_a: assert property ($rose(stop_mode) && !cfg_ff[`CFG_ASYNC_BIT]
      |-> ##[1:3] !converter_active)
      else $error("stop did not abort conversion");
   stop_hold_a: assert property (stop_mode && !cfg_ff[`CFG_ASYNC_BIT] &&
      !converter_active |=> !converter_active)
      else $error("conversion resumed in stop");
   irq_hold_a: assert property ($fell(conv_irq_req) |-> $past(psel) ||
      $past(psel, 2) || $past(psel, 3) || $past(psel, 4))
      else $error("request dropped without bus access");
   irq_mask_a: assert property (irq |-> mask_ff != 2'h0 ||
      $past(mask_ff) != 2'h0 || $past(mask_ff, 2) != 2'h0)
      else $error("irq while fully masked");
endmodule : adc_ctrl_props

bind adc_conversion_power_ctrl adc_ctrl_props #(.DIV_HALF(DIV_HALF)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .stop_mode(stop_mode), .converter_active(converter_active), .sample_on(sample_on),
   .conv_irq_req(conv_irq_req), .irq(irq));

// file: dv/adc_core_model.sv
// Behavioural comparator of the analog core
module adc_core_model (
   input  wire logic       pclk,
   input  wire logic       converter_active,
   input  wire logic [9:0] dac_code,
   input  wire logic [9:0] vin,
   output logic            comp_high = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   // A powered-down core gives no valid decision, so the line wanders
   always @(posedge pclk)
   begin
      if (converter_active)
         comp_high <= (vin >= dac_code);
      else
         comp_high <= ~comp_high;
   end
endmodule : adc_core_model

// file: dv/tb.sv
// Self-checking bench of the converter control top
`include "adc_conv_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import adc_conv_pkg::*;
   typedef struct {logic [9:0] vin; logic [3:0] cfg; logic [7:0] hi; logic [7:0] lo;} row_t;
   // Ten-bit, long sample, eight-bit saturation and rounding
   row_t rows [6] = '{'{10'h3FF, 4'h0, 8'h03, 8'hFF}, '{10'h155, 4'h1, 8'h01, 8'h55},
      '{10'h3FE, 4'h2, 8'h00, 8'hFF}, '{10'h001, 4'h2, 8'h00, 8'h00},
      '{10'h2AA, 4'h3, 8'h00, 8'hAB}, '{10'h000, 4'h0, 8'h00, 8'h00}};
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        stop_mode = 1'b0;
   logic        external_trigger = 1'b0;
   logic [9:0]  vin = 10'h000;
   logic [31:0] prdata;
   logic [31:0] rdat;
   logic        pready;
   logic        pslverr;
   logic        perr;
   logic        comp_high;
   logic        converter_active;
   logic        sample_on;
   logic        conv_irq_req;
   logic        irq;
   logic [9:0]  dac_code;
   int          num_errors = 0;
   int          comparisons = 0;

   always #2 pclk = ~pclk;

   adc_conversion_power_ctrl #(.DIV_HALF(4)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stop_mode(stop_mode), .external_trigger(external_trigger), .comp_high(comp_high),
      .converter_active(converter_active), .sample_on(sample_on), .dac_code(dac_code),
      .conv_irq_req(conv_irq_req), .irq(irq));
   adc_core_model core_model (.pclk(pclk), .converter_active(converter_active),
      .dac_code(dac_code), .vin(vin), .comp_high(comp_high));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Two idle edges after each transfer let registered flags settle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rdat = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk({31'h0000_0000, pready}, 32'h0000_0001);
      repeat (2) @(posedge pclk);
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask : rd_chk

   // Kind 0 waits for the request, kind 1 for the converter to power down
   task automatic wait_for(input int s);
      int n;
      n = 0;
      repeat (4) @(posedge pclk);
      while ((s == 0 ? conv_irq_req : !converter_active) !== 1'b1 && n < 2000)
      begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0000_0000, n < 2000}, 32'h0000_0001);
   endtask : wait_for

   task automatic wrap_up;
      $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   initial
   begin
      repeat (30000) @(posedge pclk);
      num_errors++;
      wrap_up();
   end

   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(`ADC_OFS_SCR, 32'h0000_001F);
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk({31'h0000_0000, perr}, 32'h0000_0001);
      foreach (rows[i])
      begin
         vin <= rows[i].vin;
         apb(1'b1, `ADC_OFS_CFG, {28'h000_0000, rows[i].cfg});
         apb(1'b1, `ADC_OFS_SCR, 32'h0000_0040);
         wait_for(0);
         rd_chk(`ADC_OFS_RES_HIGH, {24'h00_0000, rows[i].hi});
         rd_chk(`ADC_OFS_SCR, 32'h0000_00C0);
         rd_chk(`ADC_OFS_RES_LOW, {24'h00_0000, rows[i].lo});
         rd_chk(`ADC_OFS_SCR, 32'h0000_0040);
         chk({30'h0000_0000, conv_irq_req, converter_active}, 32'h0000_0000);
      end
      vin <= 10'h123;
      apb(1'b1, `ADC_OFS_CFG, 32'h0000_0000);
      apb(1'b1, `ADC_OFS_SCR, 32'h0000_0000);
      wait_for(1);
      repeat (4) @(posedge pclk);
      rd_chk(`ADC_OFS_SCR, 32'h0000_0080);
      chk({31'h0000_0000, conv_irq_req}, 32'h0000_0000);
      apb(1'b1, `ADC_OFS_IRQ_STS, 32'h0000_0003);
      rd_chk(`ADC_OFS_IRQ_STS, 32'h0000_0000);
      apb(1'b1, `ADC_OFS_IRQ_MSK, 32'h0000_0003);
      apb(1'b1, `ADC_OFS_SCR, 32'h0000_0040);
      repeat (40) @(posedge pclk);
      apb(1'b1, `ADC_OFS_SCR, 32'h0000_0040);
      rd_chk(`ADC_OFS_IRQ_STS, 32'h0000_0002);
      wait_for(0);
      rd_chk(`ADC_OFS_RES_LOW, 32'h0000_0023);
      apb(1'b1, `ADC_OFS_IRQ_MSK, 32'h0000_0000);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      apb(1'b1, `ADC_OFS_IRQ_MSK, 32'h0000_0003);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      apb(1'b1, `ADC_OFS_IRQ_STS, 32'h0000_0003);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      vin <= 10'h3C0;
      apb(1'b1, `ADC_OFS_SCR, 32'h0000_0040);
      repeat (40) @(posedge pclk);
      stop_mode <= 1'b1;
      repeat (4) @(posedge pclk);
      chk({31'h0000_0000, converter_active}, 32'h0000_0000);
      repeat (300) @(posedge pclk);
      stop_mode <= 1'b0;
      repeat (300) @(posedge pclk);
      chk({31'h0000_0000, converter_active}, 32'h0000_0000);
      rd_chk(`ADC_OFS_RES_LOW, 32'h0000_0023);
      apb(1'b1, `ADC_OFS_SCR, 32'h0000_0040);
      wait_for(0);
      rd_chk(`ADC_OFS_RES_LOW, 32'h0000_00C0);
      vin <= 10'h0F0;
      apb(1'b1, `ADC_OFS_CFG, 32'h0000_0004);
      apb(1'b1, `ADC_OFS_SCR, 32'h0000_0040);
      stop_mode <= 1'b1;
      wait_for(0);
      rd_chk(`ADC_OFS_RES_LOW, 32'h0000_00F0);
      vin <= 10'h20A;
      apb(1'b1, `ADC_OFS_CFG, 32'h0000_000C);
      apb(1'b1, `ADC_OFS_SCR, 32'h0000_0040);
      repeat (100) @(posedge pclk);
      chk({31'h0000_0000, converter_active}, 32'h0000_0000);
      external_trigger <= 1'b1;
      repeat (5) @(posedge pclk);
      external_trigger <= 1'b0;
      wait_for(0);
      rd_chk(`ADC_OFS_RES_LOW, 32'h0000_000A);
      stop_mode <= 1'b0;
      apb(1'b1, `ADC_OFS_CFG, 32'h0000_0000);
      apb(1'b1, `ADC_OFS_SCR, 32'h0000_0060);
      wait_for(0);
      rd_chk(`ADC_OFS_RES_LOW, 32'h0000_000A);
      wait_for(0);
      apb(1'b1, `ADC_OFS_SCR, 32'h0000_001F);
      chk({31'h0000_0000, converter_active}, 32'h0000_0000);
      repeat (400) @(posedge pclk);
      chk({31'h0000_0000, converter_active}, 32'h0000_0000);
      rd_chk(`ADC_OFS_SCR, 32'h0000_001F);
      wrap_up();
   end
endmodule : tb
